//--- src/sfp_port.sv
// Serial flash program port: byte shifter, command sequencer and timers.
`timescale 1ns/100ps
// Function
// - Input bits sampled on rising clock, output bits driven after falling clock.
// - Each transfer is one byte; commands are byte sequences.
// - Bytes shift least significant bit first both ways.
// - Read 00h: address low, high, strobe low latches addressed byte.
// - After strobe rises, latched byte shifts out with programmer clocks.
// - Programming starts at last rising edge of data byte; busy goes high.
// - Program timed internally, done within 10 us, then busy low.
// - Program verify C0h: strobe latches last programmed address for shifting out.
// - Erase is 20h twice; erase starts at last rising edge.
// - Busy high for ERASE_CNT cycles from erase start (default 1900, 9.5 us, ending before the 65536-entry array sweep), then low.
// - Erase verify A0h: address low, high, strobe latches byte for output.
// - Error check 80h shifts error byte out; bit 0 flags command error.
// - Unknown command code sets error flag and locks out all serial traffic.
// - Dropping programming supply resets command logic; error flag survives.
// - Error check clears the flag; flag undefined at power-on.
module sfp_port
    import sfp_pkg::*;
#(
    parameter int PROG_CNT = PROG_CYCLES,
    parameter int ERASE_CNT = ERASE_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic program_voltage_high,
    input wire logic sclk,
    input wire logic sda_in,
    input wire logic latch_n,
    output logic sda_out,
    output logic sda_oe,
    output logic busy
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sclk_s;
    logic [2:0] sda_s;
    logic [2:0] latch_s;
    logic [2:0] vpp_s;
    logic sclk_q;
    logic latch_q;
    logic vpp_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            sclk_s <= 3'h7;
            sda_s <= 3'h7;
            latch_s <= 3'h7;
            vpp_s <= 3'h0;
            sclk_q <= 1'b1;
            latch_q <= 1'b1;
            vpp_q <= 1'b0;
        end else begin
            sclk_s <= {sclk_s[1:0], sclk};
            sda_s <= {sda_s[1:0], sda_in};
            latch_s <= {latch_s[1:0], latch_n};
            vpp_s <= {vpp_s[1:0], program_voltage_high};
            if (sclk_s[1] == sclk_s[2]) sclk_q <= sclk_s[2];
            if (latch_s[1] == latch_s[2]) latch_q <= latch_s[2];
            if (vpp_s[1] == vpp_s[2]) vpp_q <= vpp_s[2];
        end
    end
    wire next_sclk = (sclk_s[1] == sclk_s[2]) ? sclk_s[2] : sclk_q;
    wire next_latch = (latch_s[1] == latch_s[2]) ? latch_s[2] : latch_q;
    wire next_vpp = (vpp_s[1] == vpp_s[2]) ? vpp_s[2] : vpp_q;
    wire sclk_rise = next_sclk & ~sclk_q;
    wire sclk_fall = ~next_sclk & sclk_q;
    wire latch_fall = ~next_latch & latch_q;
    wire latch_rise = next_latch & ~latch_q;
    wire vpp_drop = ~next_vpp & vpp_q;
    wire serial_on = vpp_q;

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_CMD, ST_ADDR_L, ST_ADDR_H, ST_PDATA, ST_ERASE2, ST_WAIT_STROBE,
        ST_STROBE_LOW, ST_SHIFT_OUT, ST_BUSY, ST_LOCKED
    } sfp_state_t;

    sfp_state_t state;
    logic [7:0] cmd;
    logic [7:0] rx_sh;
    logic [2:0] bit_cnt;
    logic [7:0] addr_lo;
    logic [ADDR_W-1:0] last_prog_addr;
    logic [7:0] tx_sh;
    logic err_flag;
    logic [TIMER_W-1:0] timer;
    logic tx_first;

    wire [7:0] rx_byte = {sda_s[2], rx_sh[7:1]};
    wire byte_done = sclk_rise && bit_cnt == LAST_BIT;
    wire cmd_known = cmd_is(rx_byte);

    function automatic logic cmd_is(input logic [7:0] c);
        cmd_is = (c == CMD_READ) || (c == CMD_PROG) || (c == CMD_PVER) ||
                 (c == CMD_ERASE) || (c == CMD_EVER) || (c == CMD_ECHK);
    endfunction

    // ------------------------------------------------------------
    // Two-entry request buffer toward the array
    // ------------------------------------------------------------
    sfp_req_t buf_q [BUF_DEPTH];
    logic [1:0] buf_cnt;
    logic buf_rd;
    logic buf_wr;
    logic buf_push;
    sfp_req_t next_req;
    wire buf_ready = buf_cnt < 2'(BUF_DEPTH);
    wire buf_valid = buf_cnt != 2'h0;
    wire arr_ready = 1'b1;
    wire buf_pop = buf_valid && arr_ready;
    logic [BYTE_W-1:0] arr_rdata;

    always_ff @(posedge clk) begin
        if (srst) begin
            buf_cnt <= 2'h0;
            buf_rd <= 1'b0;
            buf_wr <= 1'b0;
        end else begin
            if (buf_push && buf_ready) begin
                buf_q[buf_wr] <= next_req;
                buf_wr <= ~buf_wr;
            end
            if (buf_pop) buf_rd <= ~buf_rd;
            buf_cnt <= buf_cnt + 2'(buf_push && buf_ready) - 2'(buf_pop);
        end
    end

    sfp_flash_array u_array (
        .clk(clk),
        .req_valid(buf_pop),
        .req(buf_q[buf_rd]),
        .rdata(arr_rdata)
    );

    // Request issue: strobe fetches read, final data byte programs, second 20h erases.
    wire fetch_req = state == ST_WAIT_STROBE && latch_fall;
    wire prog_req = state == ST_PDATA && byte_done;
    wire erase_req = state == ST_ERASE2 && byte_done && rx_byte == CMD_ERASE;
    assign buf_push = fetch_req || prog_req || erase_req;
    wire [ADDR_W-1:0] rx_addr = {rx_byte, addr_lo};
    wire [ADDR_W-1:0] fetch_addr = (cmd == CMD_PVER) ? last_prog_addr : {rx_sh, addr_lo};

    always_comb begin
        next_req.op = SFP_MEM_READ;
        next_req.addr = fetch_addr;
        next_req.data = rx_byte;
        if (prog_req) begin
            next_req.op = SFP_MEM_WRITE;
            next_req.addr = last_prog_addr;
        end else if (erase_req) begin
            next_req.op = SFP_MEM_ERASE;
        end
    end

    // Read data reaches arr_rdata two clocks after the fetch push.
    logic [1:0] fetch_pipe;
    always_ff @(posedge clk) begin
        if (srst) fetch_pipe <= 2'h0;
        else fetch_pipe <= {fetch_pipe[0], fetch_req};
    end

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst || vpp_drop || !serial_on) begin
            state <= ST_CMD;
            bit_cnt <= 3'h0;
            rx_sh <= ZERO_BYTE;
            cmd <= ZERO_BYTE;
            busy <= 1'b0;
            timer <= '0;
            tx_first <= 1'b0;
        end else begin
            if (sclk_rise && state != ST_SHIFT_OUT && state != ST_LOCKED) begin
                rx_sh <= rx_byte;
                bit_cnt <= bit_cnt + 3'h1;
            end
            unique case (state)
                ST_CMD: if (byte_done) begin
                    cmd <= rx_byte;
                    if (!cmd_known) state <= ST_LOCKED;
                    else if (rx_byte == CMD_PROG || rx_byte == CMD_READ || rx_byte == CMD_EVER) state <= ST_ADDR_L;
                    else if (rx_byte == CMD_ERASE) state <= ST_ERASE2;
                    else if (rx_byte == CMD_PVER) state <= ST_WAIT_STROBE;
                    else begin
                        state <= ST_SHIFT_OUT;
                        tx_first <= 1'b1;
                    end
                end
                ST_ADDR_L: if (byte_done) state <= ST_ADDR_H;
                ST_ADDR_H: if (byte_done) begin
                    state <= (cmd == CMD_PROG) ? ST_PDATA : ST_WAIT_STROBE;
                    if (cmd == CMD_PROG) last_prog_addr <= rx_addr;
                end
                ST_PDATA: if (byte_done) begin
                    state <= ST_BUSY;
                    busy <= 1'b1;
                    timer <= TIMER_W'(PROG_CNT - 1);
                end
                ST_ERASE2: if (byte_done) begin
                    if (rx_byte == CMD_ERASE) begin
                        state <= ST_BUSY;
                        busy <= 1'b1;
                        timer <= TIMER_W'(ERASE_CNT - 1);
                    end else state <= ST_LOCKED;
                end
                ST_WAIT_STROBE: if (latch_fall) state <= ST_STROBE_LOW;
                ST_STROBE_LOW: if (latch_rise) begin
                    state <= ST_SHIFT_OUT;
                    tx_first <= 1'b0;
                end
                ST_SHIFT_OUT: begin
                    if (sclk_fall) tx_first <= 1'b0;
                    if (sclk_rise && !tx_first) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == LAST_BIT) state <= ST_CMD;
                    end
                end
                ST_BUSY: begin
                    if (timer == '0) begin
                        busy <= 1'b0;
                        state <= ST_CMD;
                    end else timer <= timer - 1'b1;
                end
                ST_LOCKED: ;
            endcase
        end
    end

    // Address low byte capture.
    always_ff @(posedge clk) begin
        if (state == ST_ADDR_L && byte_done) addr_lo <= rx_byte;
    end

    // ------------------------------------------------------------
    // Error flag: not reset by srst or the supply drop
    // ------------------------------------------------------------
    wire err_set = state == ST_CMD && byte_done && !cmd_known && serial_on;
    wire err_clr = state == ST_CMD && byte_done && rx_byte == CMD_ECHK && serial_on;
    always_ff @(posedge clk) begin
        if (err_set) err_flag <= 1'b1;
        else if (err_clr) err_flag <= 1'b0;
    end

    // ------------------------------------------------------------
    // Output shifter, LSB first after falling edges
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_sh <= ZERO_BYTE;
            sda_out <= 1'b1;
            sda_oe <= 1'b0;
        end else begin
            if (err_clr) tx_sh <= {7'h0, err_flag};
            else if (fetch_pipe[1]) tx_sh <= arr_rdata;
            if (state == ST_SHIFT_OUT && sclk_fall) begin
                sda_out <= tx_sh[0];
                tx_sh <= {1'b0, tx_sh[7:1]};
            end
            sda_oe <= state == ST_SHIFT_OUT && serial_on && !vpp_drop;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_prog_busy_rise: assert property (prog_req |=> busy) else $error("busy not raised after program");
    a_prog_busy_len: assert property (prog_req && !vpp_drop |=> busy [*8]) else $error("program busy too short");
    a_erase_busy: assert property (erase_req |=> busy) else $error("busy not raised after erase");
    a_lock_sticky: assert property (state == ST_LOCKED && !vpp_drop && serial_on |=> state == ST_LOCKED)
        else $error("locked state left without supply drop");
    a_err_set_flag: assert property (err_set |=> err_flag) else $error("error flag not set");
    a_err_clear: assert property (err_clr && !err_set |=> !err_flag) else $error("error flag not cleared");
    a_supply_reset: assert property (vpp_drop |=> state == ST_CMD && !busy) else $error("supply drop no reset");
    a_drive_only_out: assert property (sda_oe |-> $past(state) == ST_SHIFT_OUT) else $error("pin driven outside output");
    a_sda_fall_only: assert property (sda_oe && $changed(sda_out) |-> $past(sclk_fall)) else $error("sda changed off edge");

    c_program: cover property (prog_req ##[1:300] !busy);
    c_erase: cover property (erase_req);
    c_read_out: cover property (fetch_req ##[1:1000] state == ST_SHIFT_OUT);
    c_lock: cover property (err_set);
endmodule

//--- common/sfp_pkg.sv
// Package of constants and carriers for the serial flash program port.
package sfp_pkg;
    // ------------------------------------------------------------
    // Command codes and link framing
    // ------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 16;
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_PROG = 8'h40;
    localparam logic [7:0] CMD_PVER = 8'hC0;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_EVER = 8'hA0;
    localparam logic [7:0] CMD_ECHK = 8'h80;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int ERR_BIT = 0;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int PROG_TIME_US = 10;
    localparam int ERASE_TIME_NS = 9500000;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_CYCLES = ERASE_TIME_NS / 1000 * CLK_MHZ / 1000;
    localparam int TIMER_W = 24;
    localparam int BUF_DEPTH = 2;

    typedef enum logic [1:0] {SFP_MEM_READ, SFP_MEM_WRITE, SFP_MEM_ERASE} sfp_op_t;

    typedef struct packed {
        sfp_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } sfp_req_t;
endpackage

//--- src/sfp_flash_array.sv
// Flash array model: byte memory with registered read data and whole-array erase.
`timescale 1ns/100ps
module sfp_flash_array
    import sfp_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    input wire logic clk,
    input wire logic req_valid,
    input wire sfp_req_t req,
    output logic [BYTE_W-1:0] rdata
);
    logic [BYTE_W-1:0] mem [0:(1<<AW)-1];

    // Erase sweeps one entry per clock; the caller's default timer of 1900 cycles is shorter than the 65536-entry sweep, the testbench's 65540 longer.
    logic [AW-1:0] sweep;
    logic sweeping;
    // No reset reaches the array, so the sweep flag starts unknown and stays idle until the first erase.

    always_ff @(posedge clk) begin
        if (req_valid && req.op == SFP_MEM_WRITE) begin
            mem[req.addr[AW-1:0]] <= req.data;
        end
        if (sweeping) begin
            mem[sweep] <= ERASED_BYTE;
        end
        rdata <= mem[req.addr[AW-1:0]];
    end

    always_ff @(posedge clk) begin
        if (req_valid && req.op == SFP_MEM_ERASE) begin
            sweeping <= 1'b1;
            sweep <= '0;
        end else if (sweeping) begin
            sweep <= sweep + 1'b1;
            if (&sweep) begin
                sweeping <= 1'b0;
            end
        end
    end
endmodule

//--- test/sfp_prog_model.sv
// Programmer model: drives serial clock, data, strobe and programming supply.
`timescale 1ns/100ps
module sfp_prog_model (
    input wire logic clk,
    input wire logic sda_line,
    output logic sclk,
    output logic sda_drv,
    output logic latch_n,
    output logic program_voltage_high
);
    // Half of a 160 ns link period at 5 ns per cycle.
    localparam int HALF = 16;
    // Pins idle high so the device comes up in serial mode once the supply rises.
    initial begin
        sclk = 1'b1;
        sda_drv = 1'b1;
        latch_n = 1'b1;
        program_voltage_high = 1'b0;
    end
    // Released data is sent as all ones, the level the pull-up leaves on the pin.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) sclk <= 1'b0;
            sda_drv <= tx[i];
            repeat (HALF) @(posedge clk);
            rx[i] = sda_line;
            sclk <= 1'b1;
            repeat (HALF) @(posedge clk);
        end
        sda_drv <= 1'b1;
        repeat (HALF) @(posedge clk);
    endtask
    task automatic strobe();
        @(posedge clk) latch_n <= 1'b0;
        repeat (8 * HALF) @(posedge clk);
        latch_n <= 1'b1;
        repeat (2 * HALF) @(posedge clk);
    endtask
    task automatic supply_cycle();
        @(posedge clk) program_voltage_high <= 1'b0;
        repeat (HALF) @(posedge clk);
        program_voltage_high <= 1'b1;
        repeat (HALF) @(posedge clk);
    endtask
endmodule

//--- test/tb_sfp_port.sv
// Self-checking testbench for the serial flash program port.
`timescale 1ns/100ps
module tb_sfp_port;
    import sfp_pkg::*;
    localparam int PROG_N = 100;
    localparam int ERASE_N = 65540;
    logic clk, srst, sclk, sda_drv, latch_n, program_voltage_high;
    logic sda_out, sda_oe, busy, sda_line;
    int fail_count = 0;
    int check_count = 0;
    int busy_len = 0;
    int last_len = 0;
    int oe_cnt = 0;
    // The data pin carries a pull-up, so it reads high when nobody drives it.
    assign sda_line = (sda_oe === 1'b1) ? sda_out : sda_drv;
    sfp_port #(.PROG_CNT(PROG_N), .ERASE_CNT(ERASE_N)) u_sfp_port (.clk(clk), .srst(srst),
        .program_voltage_high(program_voltage_high), .sclk(sclk), .sda_in(sda_line),
        .latch_n(latch_n), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy));
    sfp_prog_model u_sfp_prog_model (.clk(clk), .sda_line(sda_line), .sclk(sclk),
        .sda_drv(sda_drv), .latch_n(latch_n), .program_voltage_high(program_voltage_high));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (busy === 1'b1) begin
            busy_len <= busy_len + 1;
        end else if (busy_len != 0) begin
            last_len <= busy_len;
            busy_len <= 0;
        end
        if (sda_oe === 1'b1) begin
            oe_cnt <= oe_cnt + 1;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic tx(input logic [7:0] b);
        logic [7:0] rx;
        u_sfp_prog_model.xfer(b, rx);
    endtask
    task automatic rx_byte(output logic [7:0] rx);
        u_sfp_prog_model.xfer(8'hFF, rx);
    endtask
    task automatic tx_addr(input logic [7:0] c, input logic [15:0] a);
        tx(c);
        tx(a[7:0]);
        tx(a[15:8]);
    endtask
    // Bounded so a stuck busy counts as a mismatch rather than a hang.
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 70000) begin
            @(posedge clk);
            n++;
        end
        if (busy !== 1'b0) begin
            fail_count++;
            $display("mismatch at %0t: busy stuck high", $time);
        end
        @(posedge clk);
    endtask
    task automatic t_err_clear();
        logic [7:0] rx;
        tx(CMD_ECHK);
        rx_byte(rx);
        tx(CMD_ECHK);
        rx_byte(rx);
        chk({7'h00, rx[ERR_BIT]}, 8'h00, "error flag after check");
        $display("test err_clear done");
    endtask
    task automatic t_program();
        logic [7:0] rx;
        int n0;
        tx_addr(CMD_PROG, 16'h12C4);
        tx(8'hB1);
        chk({7'h00, busy}, 8'h01, "busy during program");
        wait_idle();
        chk({7'h00, last_len == PROG_N}, 8'h01, "program busy length");
        repeat (1300) @(posedge clk);
        n0 = oe_cnt;
        tx(CMD_PVER);
        u_sfp_prog_model.strobe();
        rx_byte(rx);
        chk(rx, 8'hB1, "program verify data");
        chk({7'h00, oe_cnt > n0}, 8'h01, "pin driven on verify");
        tx_addr(CMD_READ, 16'h12C4);
        u_sfp_prog_model.strobe();
        rx_byte(rx);
        chk(rx, 8'hB1, "read data");
        $display("test program done");
    endtask
    task automatic t_erase();
        logic [7:0] rx;
        int n0;
        // Only the location verified below is pre-programmed; a full sweep of the array would take too long.
        tx_addr(CMD_PROG, 16'h12C4);
        tx(ZERO_BYTE);
        wait_idle();
        repeat (1300) @(posedge clk);
        tx(CMD_PVER);
        u_sfp_prog_model.strobe();
        rx_byte(rx);
        chk(rx, ZERO_BYTE, "pre-program verify data");
        tx(CMD_ERASE);
        tx(CMD_ERASE);
        chk({7'h00, busy}, 8'h01, "busy during erase");
        wait_idle();
        chk({7'h00, last_len == ERASE_N}, 8'h01, "erase busy length");
        repeat (1300) @(posedge clk);
        n0 = oe_cnt;
        tx_addr(CMD_EVER, 16'h12C4);
        u_sfp_prog_model.strobe();
        rx_byte(rx);
        chk(rx, ERASED_BYTE, "erase verify data");
        chk({7'h00, oe_cnt > n0}, 8'h01, "pin driven on erase verify");
        $display("test erase done");
    endtask
    task automatic t_bad_cmd();
        logic [7:0] rx;
        int n0;
        tx(8'h55);
        n0 = oe_cnt;
        tx(CMD_ECHK);
        rx_byte(rx);
        chk({7'h00, oe_cnt == n0}, 8'h01, "pin driven while locked");
        tx_addr(CMD_PROG, 16'h0000);
        tx(ZERO_BYTE);
        chk({7'h00, busy}, 8'h00, "busy while locked");
        u_sfp_prog_model.supply_cycle();
        tx(CMD_ECHK);
        rx_byte(rx);
        chk({7'h00, rx[ERR_BIT]}, 8'h01, "error flag kept");
        tx(CMD_ECHK);
        rx_byte(rx);
        chk({7'h00, rx[ERR_BIT]}, 8'h00, "error flag cleared");
        $display("test bad_cmd done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        srst = 1'b1;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        repeat (8) @(posedge clk);
        u_sfp_prog_model.supply_cycle();
        t_err_clear();
        t_program();
        t_erase();
        t_bad_cmd();
        report_and_stop();
    end
    // The tests need about 81000 cycles; this margin covers them.
    initial begin
        repeat (95000) @(posedge clk);
        fail_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule
